// File: src/sfbc_core.sv
// serial command interpreter for buffer moves, setup and status access
// Operation
// - 92H plus three zero words then chip select high copies all SRAM into buffer
// - a buffer copy runs for the copy time, both buffers blocked, flagged
// - 91H reads program buffer from byte address; refused while busy
// - 55H plus three zero words copies buffer into SRAM; refused while busy
// - setup read gives ready word then 16-bit setup field, low nine used
// - setup holds hold/ready pin use, read edge, protect range, oscillator
// - setup contents are non-volatile with finite write endurance
// - after a setup write the device reports busy for the program time
// - status read gives ready word then the 8-bit flags byte
// - flags hold ready, copy pending, write permission and mismatch
// - mismatch flag sets on compare difference, cleared only by 89H
// - read-only information sector lists part details and restricted sectors
// - first sector byte ships holding the tag/sync value
// - failed sectors carry a non-tag pattern in their first three bytes
// - buffer byte address increments per byte and wraps after the last
`timescale 1ns/1ps
`default_nettype none
module sfbc_core
	import sfbc_pkg::*;
#(
	parameter int WP_CYCLES = WP_CYC_DOC,
	parameter logic [7:0] INFO_PART = 8'h5A, // arbitrary value
	parameter logic [7:0] INFO_DENS = 8'h08 // arbitrary value
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic write_en_state,
	input wire logic mismatch_event,
	output logic so,
	output logic so_oe,
	output logic rdy_pin,
	output logic rdy_pin_oe,
	output sfbc_cfg_t setup_field
);
	logic cs_s1_reg, cs_s2_reg, cs_d_reg;
	logic sck_s1_reg, sck_s2_reg, sck_d_reg, rise_d_reg;
	logic si_s1_reg, si_s2_reg;
	logic sck_rise, sck_fall, cs_rise, out_evt;
	logic [15:0] bitcnt_reg, shift_reg, cfgw_reg;
	logic [7:0] opcode_reg;
	logic [AW-1:0] addr_reg, copy_idx_reg;
	logic [2:0] bidx_reg;
	logic nz_reg, rd_ok_reg, mismatch_reg;
	logic [TW-1:0] timer_reg;
	sfbc_state_t state_reg;
	sfbc_cfg_t cfg_reg, cfgw_masked;
	sfbc_stat_t flags_byte;
	logic [15:0] ready_word, dstart, pos;
	logic [7:0] sram [0:BUF_BYTES-1];
	logic [7:0] pbuf [0:BUF_BYTES-1];
	logic [7:0] rdbyte, opc_next, in_byte;
	logic in_data, byte_done, ready, moving, wr_byte, out_bit, cmd_ok;
	logic clr_cmp, copy_step;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// pins are asynchronous to clk; logic reads only the second stage and its one-cycle delayed copy
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_d_reg <= 1'b1;
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_d_reg <= 1'b0;
			rise_d_reg <= 1'b0;
			si_s1_reg <= 1'b0;
			si_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_d_reg <= cs_s2_reg;
			sck_s1_reg <= sck;
			sck_s2_reg <= sck_s1_reg;
			sck_d_reg <= sck_s2_reg;
			rise_d_reg <= sck_rise;
			si_s1_reg <= si;
			si_s2_reg <= si_s1_reg;
		end
	end

	assign sck_rise = !cs_s2_reg && sck_s2_reg && !sck_d_reg;
	assign sck_fall = !cs_s2_reg && !sck_s2_reg && sck_d_reg;
	assign cs_rise = cs_s2_reg && !cs_d_reg;
	// output changes after the rise that advanced the counters, or on fall
	assign out_evt = cfg_reg.rd_rise ? rise_d_reg : sck_fall;
	assign ready = (state_reg == ST_IDLE);
	assign moving = (state_reg == ST_TO_PBUF) || (state_reg == ST_TO_SRAM);
	assign ready_word = ready ? RB_READY : RB_BUSY;
	assign flags_byte = '{rsvd: 4'h0, mismatch: mismatch_reg,
		write_en: write_en_state, moving: moving, ready: ready};
	assign dstart = (opcode_reg == CMD_WR_SRAM) ? F2_END : CTL_END;
	assign in_data = (bitcnt_reg >= dstart);
	assign byte_done = sck_rise && in_data && (bidx_reg == BIT_LAST);
	assign in_byte = {shift_reg[6:0], si_s2_reg};
	assign opc_next = in_byte;
	assign wr_byte = byte_done && (opcode_reg == CMD_WR_SRAM) && !moving;
	assign cfgw_masked = '{rsvd: 7'h00, alt_osc: cfgw_reg[8:6],
		wp_range: cfgw_reg[5:2], rd_rise: cfgw_reg[1],
		hold_is_rdy: cfgw_reg[0]};
	assign clr_cmp = cs_rise && (opcode_reg == CMD_CLR_CMP)
		&& (bitcnt_reg >= OPC_END);
	assign copy_step = moving && (copy_idx_reg <= BYTE_LAST);
	assign cmd_ok = rd_ok_reg && (bitcnt_reg >= CTL_END);

	function automatic logic [7:0] info_byte(input logic [AW-1:0] a);
		case (a)
			10'h000: info_byte = TAG_SYNC;
			10'h001: info_byte = INFO_PART;
			10'h002: info_byte = INFO_DENS;
			10'h003: info_byte = INFO_NO_RESTRICT;
			10'h004: info_byte = BAD_MARK;
			default: info_byte = INFO_FILL;
		endcase
	endfunction

	// frame counters and field capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bitcnt_reg <= 16'h0000;
			shift_reg <= 16'h0000;
			opcode_reg <= 8'h00;
			cfgw_reg <= 16'h0000;
			nz_reg <= 1'b0;
			rd_ok_reg <= 1'b0;
		end else if (cs_s2_reg) begin
			bitcnt_reg <= 16'h0000;
			nz_reg <= 1'b0;
			rd_ok_reg <= 1'b0;
		end else if (sck_rise) begin
			shift_reg <= {shift_reg[14:0], si_s2_reg};
			if (bitcnt_reg != BITCNT_MAX)
				bitcnt_reg <= bitcnt_reg + 16'h0001;
			if (bitcnt_reg >= OPC_END && bitcnt_reg < CTL_END && si_s2_reg)
				nz_reg <= 1'b1;
			if (bitcnt_reg == OPC_END - 16'h0001) begin
				opcode_reg <= opc_next;
				case (opc_next)
					CMD_RD_PBUF, CMD_RD_INFO: rd_ok_reg <= ready;
					CMD_RD_SRAM: rd_ok_reg <= !moving;
					CMD_RD_CFG, CMD_RD_STAT: rd_ok_reg <= 1'b1;
					default: rd_ok_reg <= 1'b0;
				endcase
			end
			if (bitcnt_reg == F1_LAST)
				cfgw_reg <= {shift_reg[14:0], si_s2_reg};
		end
	end

	// byte address walk with wrap after the last byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_reg <= '0;
			bidx_reg <= 3'h0;
		end else if (cs_s2_reg) begin
			bidx_reg <= 3'h0;
		end else if (sck_rise) begin
			if (bitcnt_reg == F2_LAST) begin
				if ({shift_reg[8:0], si_s2_reg} > BYTE_LAST)
					addr_reg <= '0;
				else
					addr_reg <= {shift_reg[8:0], si_s2_reg};
			end else if (in_data) begin
				bidx_reg <= bidx_reg + 3'h1;
				if (byte_done)
					addr_reg <= (addr_reg >= BYTE_LAST) ? '0
						: addr_reg + 10'h001;
			end
		end
	end

	// read stream: ready word leads the setup and flags fields
	always_comb begin
		pos = bitcnt_reg - CTL_END;
		case (opcode_reg)
			CMD_RD_PBUF: rdbyte = pbuf[addr_reg];
			CMD_RD_SRAM: rdbyte = sram[addr_reg];
			CMD_RD_INFO: rdbyte = info_byte(addr_reg);
			default: rdbyte = 8'h00;
		endcase
		out_bit = rdbyte[BIT_LAST - bidx_reg];
		if (opcode_reg == CMD_RD_STAT) begin
			if (pos < RB_LEN)
				out_bit = ready_word[4'hF - pos[3:0]];
			else if (pos < ST_END)
				out_bit = flags_byte[BIT_LAST - pos[2:0]];
			else
				out_bit = 1'b0;
		end else if (opcode_reg == CMD_RD_CFG) begin
			if (pos < RB_LEN)
				out_bit = ready_word[4'hF - pos[3:0]];
			else if (pos < CF_END)
				out_bit = cfg_reg[4'hF - pos[3:0]];
			else
				out_bit = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (cs_s2_reg) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (out_evt) begin
			so_oe <= cmd_ok;
			if (cmd_ok)
				so <= out_bit;
		end
	end

	// copy, setup programming and busy timing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
			copy_idx_reg <= '0;
			cfg_reg <= CFG_RESET;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					copy_idx_reg <= '0;
					if (cs_rise && bitcnt_reg == CTL_END && !nz_reg) begin
						if (opcode_reg == CMD_SRAM_TO_PB) begin
							state_reg <= ST_TO_PBUF;
							timer_reg <= TW'(XP_CYC - 1);
						end else if (opcode_reg == CMD_PB_TO_SRAM) begin
							state_reg <= ST_TO_SRAM;
							timer_reg <= TW'(XP_CYC - 1);
						end
					end else if (cs_rise && bitcnt_reg == F2_END
						&& opcode_reg == CMD_WR_CFG) begin
						// cells hold over power loss; reset still loads CFG_RESET and drops the written value
						cfg_reg <= cfgw_masked;
						state_reg <= ST_CFG_PROG;
						timer_reg <= TW'(WP_CYCLES - 1);
					end
				end
				ST_TO_PBUF, ST_TO_SRAM, ST_CFG_PROG: begin
					if (copy_step)
						copy_idx_reg <= copy_idx_reg + 10'h001;
					if (timer_reg == '0)
						state_reg <= ST_IDLE;
					else
						timer_reg <= timer_reg - TW'(1);
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// program buffer starts as a fresh sector image, tag byte first; SRAM resets to all zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < BUF_BYTES; i++)
				sram[i] <= 8'h00;
		end else if (copy_step && state_reg == ST_TO_SRAM) begin
			sram[copy_idx_reg] <= pbuf[copy_idx_reg];
		end else if (wr_byte) begin
			sram[addr_reg] <= in_byte;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < BUF_BYTES; i++)
				pbuf[i] <= (i == 0) ? TAG_SYNC : 8'h00;
		end else if (copy_step && state_reg == ST_TO_PBUF) begin
			pbuf[copy_idx_reg] <= sram[copy_idx_reg];
		end
	end

	// a difference arriving with the clear command still sets the flag
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			mismatch_reg <= 1'b0;
		else if (mismatch_event)
			mismatch_reg <= 1'b1;
		else if (clr_cmp)
			mismatch_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdy_pin <= 1'b0;
			rdy_pin_oe <= 1'b0;
		end else begin
			rdy_pin <= ready;
			rdy_pin_oe <= cfg_reg.hold_is_rdy;
		end
	end
	assign setup_field = cfg_reg;

	// checking helpers
	int move_cnt, prog_cnt;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			move_cnt <= 0;
			prog_cnt <= 0;
		end else begin
			move_cnt <= moving ? move_cnt + 1 : 0;
			prog_cnt <= (state_reg == ST_CFG_PROG) ? prog_cnt + 1 : 0;
		end
	end

	property p_copy_start;
		cs_rise && ready && opcode_reg == CMD_SRAM_TO_PB
			&& bitcnt_reg == CTL_END && !nz_reg |=> state_reg == ST_TO_PBUF;
	endproperty
	a_copy_start: assert property (p_copy_start)
		else $error("copy to buffer did not start");
	property p_copy_time;
		$fell(moving) |-> move_cnt == XP_CYC;
	endproperty
	a_copy_time: assert property (p_copy_time)
		else $error("copy busy time wrong");
	property p_copy_data;
		$past(state_reg) == ST_TO_PBUF && ready |->
			pbuf[BYTE_LAST] == sram[BYTE_LAST] && pbuf[0] == sram[0];
	endproperty
	a_copy_data: assert property (p_copy_data)
		else $error("buffer copy incomplete");
	property p_busy_refuse;
		cs_rise && !ready && opcode_reg == CMD_PB_TO_SRAM
			|=> state_reg == $past(state_reg);
	endproperty
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("copy accepted while busy");
	property p_prog_time;
		$fell(state_reg == ST_CFG_PROG) |-> prog_cnt == WP_CYCLES;
	endproperty
	a_prog_time: assert property (p_prog_time)
		else $error("setup program time wrong");
	property p_cfg_rsvd;
		cfg_reg.rsvd == 7'h00;
	endproperty
	a_cfg_rsvd: assert property (p_cfg_rsvd)
		else $error("reserved setup bits set");
	property p_mm_set;
		mismatch_event |=> mismatch_reg ##1 mismatch_reg || $past(clr_cmp);
	endproperty
	a_mm_set: assert property (p_mm_set)
		else $error("mismatch flag not set");
	property p_mm_hold;
		mismatch_reg && !clr_cmp |=> mismatch_reg;
	endproperty
	a_mm_hold: assert property (p_mm_hold)
		else $error("mismatch flag lost");
	property p_wrap;
		byte_done && addr_reg == BYTE_LAST |=> addr_reg == '0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("byte address did not wrap");
	property p_oe_phase;
		// so_oe is registered, so it lags deselect by one cycle
		so_oe |-> $past(!cs_s2_reg && bitcnt_reg >= CTL_END && rd_ok_reg);
	endproperty
	a_oe_phase: assert property (p_oe_phase)
		else $error("output driven outside read data");
	property p_rdy_pin;
		ready |=> rdy_pin;
	endproperty
	a_rdy_pin: assert property (p_rdy_pin)
		else $error("ready pin wrong");
	c_to_pbuf: cover property ($rose(state_reg == ST_TO_PBUF));
	c_to_sram: cover property ($rose(state_reg == ST_TO_SRAM));
	c_cfg_prog: cover property ($rose(state_reg == ST_CFG_PROG));
	c_clear: cover property (mismatch_reg && clr_cmp);
endmodule
`default_nettype wire

// File: src/sfbc_pkg.sv
// shared constants and types of the serial flash buffer/config command block
package sfbc_pkg;
	localparam int AW = 10;
	localparam logic [AW-1:0] BYTE_LAST = 10'h217;
	localparam int BUF_BYTES = 536;
	localparam logic [7:0] CMD_SRAM_TO_PB = 8'h92;
	localparam logic [7:0] CMD_RD_PBUF = 8'h91;
	localparam logic [7:0] CMD_PB_TO_SRAM = 8'h55;
	localparam logic [7:0] CMD_WR_CFG = 8'h8A;
	localparam logic [7:0] CMD_RD_CFG = 8'h8B;
	localparam logic [7:0] CMD_RD_STAT = 8'h83;
	localparam logic [7:0] CMD_CLR_CMP = 8'h89;
	localparam logic [7:0] CMD_RD_INFO = 8'h15;
	localparam logic [7:0] CMD_WR_SRAM = 8'h82;
	localparam logic [7:0] CMD_RD_SRAM = 8'h81;
	// frame positions in serial clocks, counted from the command's first bit or, for RB_LEN, ST_END and CF_END, from CTL_END
	localparam logic [15:0] OPC_END = 16'h0008;
	localparam logic [15:0] F1_LAST = 16'h0017;
	localparam logic [15:0] F2_LAST = 16'h0027;
	localparam logic [15:0] F2_END = 16'h0028;
	localparam logic [15:0] CTL_END = 16'h0038;
	localparam logic [15:0] RB_LEN = 16'h0010;
	localparam logic [15:0] ST_END = 16'h0018;
	localparam logic [15:0] CF_END = 16'h0020;
	localparam logic [15:0] BITCNT_MAX = 16'hFFFF;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [15:0] RB_READY = 16'hFFFF;
	localparam logic [15:0] RB_BUSY = 16'h0000;
	localparam logic [7:0] TAG_SYNC = 8'hC9;
	localparam logic [7:0] BAD_MARK = 8'h00;
	localparam logic [7:0] INFO_NO_RESTRICT = 8'h00;
	localparam logic [7:0] INFO_FILL = 8'hFF;
	localparam int CLK_NS = 25;
	localparam int T_XP_NS = 100000;
	localparam int XP_CYC = T_XP_NS / CLK_NS;
	localparam int T_WP_NS = 5000000;
	localparam int WP_CYC_DOC = T_WP_NS / CLK_NS;
	localparam int TW = 20;
	typedef struct packed {
		logic [6:0] rsvd;
		logic [2:0] alt_osc;
		logic [3:0] wp_range;
		logic rd_rise;
		logic hold_is_rdy;
	} sfbc_cfg_t;
	localparam sfbc_cfg_t CFG_RESET = 16'h0000;
	typedef struct packed {
		logic [3:0] rsvd;
		logic mismatch;
		logic write_en;
		logic moving;
		logic ready;
	} sfbc_stat_t;
	typedef enum {ST_IDLE, ST_TO_PBUF, ST_TO_SRAM, ST_CFG_PROG} sfbc_state_t;
endpackage

// File: verif/sfbc_master.sv
// spi master model that clocks whole frames into the command block
`timescale 1ns/1ps
`default_nettype none
module sfbc_master (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	// half sck period in clk cycles; 4 gives the 200 ns link period
	int half = 4;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// tx goes out msb first; so is taken late in the high phase,
	// since the device only updates it a few clk after the pin edge
	task automatic frame(input logic [127:0] tx, input int n,
		output logic [127:0] rx);
		rx = '0;
		tick(1);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = tx[127 - i];
			tick(half);
			sck = 1'b1;
			tick(half);
			rx = {rx[126:0], so};
			sck = 1'b0;
		end
		tick(half);
		cs_n = 1'b1;
		// released line must not keep showing the last bit
		si = ~si;
		tick(8);
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for buffer moves, setup and status commands
`timescale 1ns/1ps
`default_nettype none
module testbench
	import sfbc_pkg::*;
();
	localparam int WPC = 50;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic write_en_state = 1'b1;
	logic mismatch_event = 1'b0;
	logic cs_n, sck, si, so, so_oe, rdy_pin, rdy_pin_oe;
	sfbc_cfg_t setup_field;
	logic [127:0] rx;
	int n_mismatch = 0;
	int cmp_count = 0;
	int busy_cnt = 0;
	logic oe_seen = 1'b0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (rdy_pin === 1'b0)
			busy_cnt++;
		if (so_oe === 1'b1)
			oe_seen = 1'b1;
	end
	sfbc_core #(.WP_CYCLES(WPC)) dut (
		.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
		.write_en_state(write_en_state), .mismatch_event(mismatch_event),
		.so(so), .so_oe(so_oe), .rdy_pin(rdy_pin),
		.rdy_pin_oe(rdy_pin_oe), .setup_field(setup_field)
	);
	sfbc_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic fr(input logic [7:0] op, input logic [15:0] s,
		input logic [15:0] b, input logic [87:0] d, input int n);
		m.frame({op, s, b, d}, n, rx);
	endtask
	// bounded wait for ready, then the busy length seen on the pin
	task automatic wait_rdy(input int exp);
		for (int k = 0; k < 6000 && rdy_pin !== 1'b1; k++)
			m.tick(1);
		chk("ready after busy", 1, rdy_pin);
		if (rdy_pin !== 1'b1)
			final_report();
		chk("busy cycles", exp, busy_cnt);
	endtask
	task automatic status(input logic [7:0] fl, input logic [15:0] rw);
		fr(CMD_RD_STAT, 0, 0, 0, 80);
		chk("status word", {rw, fl}, rx[23:0]);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		chk("setup in reset", 0, setup_field);
		chk("rdy in reset", 0, rdy_pin);
		chk("so_oe in reset", 0, so_oe);
		#1 reset_n = 1'b1;
		m.tick(4);
		chk("rdy after reset", 1, rdy_pin);
		status(8'h05, 16'hFFFF);
		fr(CMD_RD_PBUF, 0, 16'h0217, 0, 72);
		chk("pbuf wrap", 16'h00C9, rx[15:0]);
		fr(CMD_WR_SRAM, 0, 0, {16'hA53C, 72'h0}, 56);
		busy_cnt = 0;
		fr(CMD_SRAM_TO_PB, 0, 0, 0, 56);
		status(8'h06, 16'h0000);
		oe_seen = 1'b0;
		fr(CMD_RD_PBUF, 0, 0, 0, 64);
		chk("pbuf read busy", 0, oe_seen);
		fr(CMD_PB_TO_SRAM, 0, 0, 0, 56);
		wait_rdy(4000);
		status(8'h05, 16'hFFFF);
		fr(CMD_RD_PBUF, 0, 0, 0, 72);
		chk("pbuf after copy", 16'hA53C, rx[15:0]);
		fr(CMD_WR_SRAM, 0, 0, {16'h1122, 72'h0}, 56);
		busy_cnt = 0;
		fr(CMD_PB_TO_SRAM, 0, 0, 0, 56);
		wait_rdy(4000);
		fr(CMD_RD_SRAM, 0, 0, 0, 72);
		chk("sram after copy", 16'hA53C, rx[15:0]);
		// a stray bit or a short frame must start no copy
		busy_cnt = 0;
		fr(CMD_SRAM_TO_PB, 16'h0001, 0, 0, 56);
		fr(CMD_PB_TO_SRAM, 0, 0, 0, 48);
		m.tick(20);
		chk("refused copies", 0, busy_cnt);
		m.tick(0);
		mismatch_event = 1'b1;
		m.tick(1);
		mismatch_event = 1'b0;
		status(8'h0D, 16'hFFFF);
		status(8'h0D, 16'hFFFF);
		fr(CMD_CLR_CMP, 0, 0, 0, 8);
		status(8'h05, 16'hFFFF);
		// slower master for the information sector
		m.half = 8;
		fr(CMD_RD_INFO, 0, 0, 0, 104);
		m.half = 4;
		chk("info head", 24'hC95A08, rx[47:24]);
		chk("info marks", 24'h0000FF, rx[23:0]);
		fr(CMD_RD_CFG, 0, 0, 0, 88);
		chk("setup read", 32'hFFFF0000, rx[31:0]);
		busy_cnt = 0;
		// upper reserved ones must be dropped; read edge stays falling
		fr(CMD_WR_CFG, 16'hFFFD, 0, 0, 40);
		wait_rdy(WPC);
		chk("setup field", 16'h01FD, setup_field);
		chk("ready pin oe", 1, rdy_pin_oe);
		fr(CMD_RD_CFG, 0, 0, 0, 88);
		chk("setup readback", 32'hFFFF01FD, rx[31:0]);
		final_report();
	end
endmodule
`default_nettype wire
